// file: logic/poe_map.svh
// output-disable trip controller: register map, field positions, codes, divider taps
// assumes APB byte addressing, one 32-bit word per register
`ifndef POE_MAP_SVH
`define POE_MAP_SVH

`define TRIP_CNT        9
`define MOTOR_PINS      20
`define PWM_PINS        20
`define CMP_W           4
`define ADDR_W          12

// register byte offsets
`define TRIP_CTRL_BASE  12'h000
`define STATUS_ADDR     12'h024
`define MASK_ADDR       12'h028
`define SWREQ_ADDR      12'h02C
`define OUTCFG_ADDR     12'h030

// trip control fields and reset
`define CTRL_MODE       3:0
`define CTRL_CNT        11:8
`define CTRL_RST        16'h0000
`define CTRL_WMASK      16'h0F0F

// status / mask bit positions (bits 0..8 are trip inputs)
`define ST_SW           9
`define ST_OSC          10
`define ST_CMP          11
`define ST_MSHORT       12
`define ST_PSHORT       13
`define ST_W            14
`define MASK_RST        14'h0000

// output config bits
`define OC_GPIO         0
`define OC_MOT_LOW      1
`define OC_PWM_LOW      2
`define OUTCFG_RST      3'h0

// mode codes
`define MODE_EDGE       4'h0
`define MODE_DIV8       4'h1
`define MODE_DIV16      4'h2
`define MODE_DIV128     4'h3
`define MODE_DIV1       4'h4
`define MODE_DIV2       4'h5
`define MODE_DIV4       4'h6

// sample count select codes and counts
`define CNT_SEL_16      4'h0
`define CNT_SEL_8       4'h1
`define CNT_SEL_4       4'h2
`define CNT_16          5'h10
`define CNT_8           5'h08
`define CNT_4           5'h04

// strobe vector positions and divider width
`define STB_DIV1        0
`define STB_DIV2        1
`define STB_DIV4        2
`define STB_DIV8        3
`define STB_DIV16       4
`define STB_DIV128      5
`define STB_W           6
`define DIV_CNT_W       7

`endif

// file: logic/poe_pkg.sv
// output-disable trip controller: shared types
// assumes poe_map.svh is on the include path
`include "poe_map.svh"
package poe_pkg;
    typedef logic [3:0]             nibble_t;
    typedef logic [`STB_W-1:0]      strobe_t;
    typedef logic [`ST_W-1:0]       status_t;
    typedef struct packed {
        nibble_t cnt_sel;
        nibble_t mode;
    } trip_cfg_s;
endpackage

// file: logic/trip_if.sv
// output-disable trip controller: link between controller and one trip detector
// assumes one clock domain on both ends
`timescale 1ns/1ps
interface trip_if;
    import poe_pkg::*;
    trip_cfg_s cfg;
    strobe_t   strobe;
    logic      req;
    modport ctrl (output cfg, output strobe, input req);
    modport det  (input cfg, input strobe, output req);
endinterface

// file: logic/sample_strobe_div.sv
// output-disable trip controller: sampling strobe divider
// assumes a free-running clock; strobes are one-cycle enables
`timescale 1ns/1ps
`include "poe_map.svh"
module sample_strobe_div
    import poe_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk_in,
    input  wire logic srst_in,
    // enables
    output strobe_t   strobe_out
);
    logic [`DIV_CNT_W-1:0] div_cnt_r;

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            div_cnt_r <= '0;
        end else begin
            div_cnt_r <= div_cnt_r + 1'b1;
        end
    end

    always_comb begin
        strobe_out                = '0;
        strobe_out[`STB_DIV1]     = 1'b1;
        strobe_out[`STB_DIV2]     = div_cnt_r[0];
        strobe_out[`STB_DIV4]     = &div_cnt_r[1:0];
        strobe_out[`STB_DIV8]     = &div_cnt_r[2:0];
        strobe_out[`STB_DIV16]    = &div_cnt_r[3:0];
        strobe_out[`STB_DIV128]   = &div_cnt_r;
    end
endmodule

// file: logic/trip_detector.sv
// output-disable trip controller: edge / low-level detector for one trip input
// assumes the level input is already synchronised to ref_clk_in
`timescale 1ns/1ps
`include "poe_map.svh"
module trip_detector
    import poe_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk_in,
    input  wire logic srst_in,
    // synchronised pin level, high = idle
    input  wire logic trip_lvl_in,
    // controller side
    trip_if.det       link
);
    logic       lvl_d_r;
    logic [4:0] low_cnt_r;
    logic       stb;
    logic       lvl_mode;
    logic [4:0] needed;

    // strobe pick per mode code; undefined codes never sample
    always_comb begin
        stb      = 1'b0;
        lvl_mode = 1'b1;
        case (link.cfg.mode)
            `MODE_DIV8:   stb = link.strobe[`STB_DIV8];
            `MODE_DIV16:  stb = link.strobe[`STB_DIV16];
            `MODE_DIV128: stb = link.strobe[`STB_DIV128];
            `MODE_DIV1:   stb = link.strobe[`STB_DIV1];
            `MODE_DIV2:   stb = link.strobe[`STB_DIV2];
            `MODE_DIV4:   stb = link.strobe[`STB_DIV4];
            default:      lvl_mode = 1'b0;
        endcase
    end

    always_comb begin
        case (link.cfg.cnt_sel)
            `CNT_SEL_8: needed = `CNT_8;
            `CNT_SEL_4: needed = `CNT_4;
            default:    needed = `CNT_16;
        endcase
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            lvl_d_r <= 1'b1;
        end else begin
            lvl_d_r <= trip_lvl_in;
        end
    end

    // consecutive low samples; a high sample restarts the run
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !lvl_mode) begin
            low_cnt_r <= '0;
        end else if (stb) begin
            if (trip_lvl_in) begin
                low_cnt_r <= '0;
            end else if (low_cnt_r < needed) begin
                low_cnt_r <= low_cnt_r + 5'h01;
            end
        end
    end

    // after a full run the request repeats while the pin stays low
    assign link.req = (link.cfg.mode == `MODE_EDGE && lvl_d_r && !trip_lvl_in) ||
                      (lvl_mode && !trip_lvl_in && low_cnt_r == needed) ||
                      (lvl_mode && stb && !trip_lvl_in && low_cnt_r == needed - 5'h01);

    a_edge_req: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (link.cfg.mode == `MODE_EDGE && $fell(trip_lvl_in)) |-> link.req)
        else $error("falling edge not accepted");
    a_level_run: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        (link.req && link.cfg.mode != `MODE_EDGE) |-> (!trip_lvl_in && lvl_mode && low_cnt_r >= needed - 5'h01))
        else $error("level request without full low run");
    c_level_req: cover property (@(posedge ref_clk_in) disable iff (srst_in)
        link.req && link.cfg.mode == `MODE_DIV1);
endmodule

// file: logic/poe_ctrl.sv
// output-disable trip controller: APB registers, trip sources, short detect, pin gating
// assumes trip pins, oscillator-stop and comparator levels are asynchronous; timer outputs share ref_clk_in
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "poe_map.svh"

// Summary of operation
// - An accepted disable request either floats each affected pin or hands it to the general I/O port.
// - Gated pins are motor timer ch0 A-D, ch3 B/D, ch4 A-D, ch6 B/D, ch7 A-D, ch9 A-D and PWM ch0-9 A/B.
// - Each of nine active-low trip inputs triggers on a falling edge or on a sustained low level.
// - The low-level sampling strobe is the clock undivided or divided by 2, 4, 8, 16 or 128.
// - Low-level mode needs a run of four, eight or sixteen consecutive low samples.
// - Mode code 0000 accepts a request on a falling edge of the trip input.
// - Codes 0001 to 0101 sample at clock/8, /16, /128, /1 and /2 and accept after the low run.
// - Code 0110 samples at clock/4; other codes are not to be written and never trigger.
// - Every trip input has its own four-bit sample count select field.
// - Any write to the software disable request register raises a disable request.
// - A main oscillator stop report raises a disable request.
// - A comparator detection raises a disable request.
// - Motor outputs are disabled when 3B/3D, 4A/4C, 4B/4D, 6B/6D, 7A/7C or 7B/7D are both active.
// - PWM outputs are disabled when A and B of channel 0-2 or 4-9 are both active.
// - Trip sampling and output comparison results can raise an interrupt.
module poe_ctrl
    import poe_pkg::*;
(
    // clock and reset
    input  wire logic                     ref_clk_in,
    input  wire logic                     srst_in,
    // APB slave
    input  wire logic [`ADDR_W-1:0]       paddr_in,
    input  wire logic                     psel_in,
    input  wire logic                     penable_in,
    input  wire logic                     pwrite_in,
    input  wire logic [31:0]              pwdata_in,
    output logic      [31:0]              prdata_out,
    output logic                          pready_out,
    output logic                          pslverr_out,
    // fault sources
    input  wire logic [`TRIP_CNT-1:0]     trip_in_n_in,
    input  wire logic                     osc_stop_in,
    input  wire logic [`CMP_W-1:0]        cmp_det_in,
    // timer outputs to be gated
    input  wire logic [`MOTOR_PINS-1:0]   motor_pwm_in,
    input  wire logic [`PWM_PINS-1:0]     gen_pwm_in,
    // gated pins
    output logic      [`MOTOR_PINS-1:0]   motor_pin_out,
    output logic      [`MOTOR_PINS-1:0]   motor_pin_oe_n_out,
    output logic      [`MOTOR_PINS-1:0]   motor_gpio_sel_out,
    output logic      [`PWM_PINS-1:0]     pwm_pin_out,
    output logic      [`PWM_PINS-1:0]     pwm_pin_oe_n_out,
    output logic      [`PWM_PINS-1:0]     pwm_gpio_sel_out,
    // interrupt
    output logic                          irq_out
);
    localparam int SYNC_W = `TRIP_CNT + 1 + `CMP_W;

    logic [SYNC_W-1:0]       sync1_r;
    logic [SYNC_W-1:0]       sync2_r;
    logic [15:0]             ctrl_r [`TRIP_CNT];
    status_t                 status_r;
    status_t                 mask_r;
    logic [2:0]              outcfg_r;
    logic [31:0]             rd_data;
    logic                    addr_ok;
    logic                    setup_ph;
    logic                    access_ph;
    logic                    wr_acc;
    logic                    rd_status;
    logic [`TRIP_CNT-1:0]    trip_req;
    strobe_t                 strobe;
    status_t                 set_vec;
    logic [`MOTOR_PINS-1:0]  mot_act;
    logic [`PWM_PINS-1:0]    pwm_act;
    logic                    mot_short;
    logic                    pwm_short;
    logic                    sw_wr;
    logic                    mot_dis;
    logic                    pwm_dis;
    logic [3:0]              ctrl_idx;

    // two-stage synchroniser for all asynchronous sources
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            sync1_r <= {SYNC_W{1'b0}} | {{(`CMP_W + 1){1'b0}}, {`TRIP_CNT{1'b1}}};
            sync2_r <= {SYNC_W{1'b0}} | {{(`CMP_W + 1){1'b0}}, {`TRIP_CNT{1'b1}}};
        end else begin
            sync1_r <= {cmp_det_in, osc_stop_in, trip_in_n_in};
            sync2_r <= sync1_r;
        end
    end

    sample_strobe_div u_div (
        .ref_clk_in (ref_clk_in),
        .srst_in    (srst_in),
        .strobe_out (strobe)
    );

    // one detector per trip input
    for (genvar g = 0; g < `TRIP_CNT; g++) begin : g_trip
        trip_if link ();
        assign link.cfg.mode    = ctrl_r[g][`CTRL_MODE];
        assign link.cfg.cnt_sel = ctrl_r[g][`CTRL_CNT];
        assign link.strobe      = strobe;
        assign trip_req[g]      = link.req;
        trip_detector u_det (
            .ref_clk_in  (ref_clk_in),
            .srst_in     (srst_in),
            .trip_lvl_in (sync2_r[g]),
            .link        (link.det)
        );
    end

    // APB decode
    assign setup_ph  = psel_in && !penable_in;
    assign access_ph = psel_in && penable_in;
    assign wr_acc    = access_ph && pwrite_in && addr_ok;
    assign rd_status = access_ph && !pwrite_in && paddr_in == `STATUS_ADDR;
    assign sw_wr     = wr_acc && paddr_in == `SWREQ_ADDR;
    assign ctrl_idx  = paddr_in[5:2];
    assign pready_out  = 1'b1;
    assign pslverr_out = access_ph && !addr_ok;

    always_comb begin
        addr_ok = 1'b1;
        rd_data = '0;
        if (paddr_in[1:0] != 2'h0) begin
            addr_ok = 1'b0;
        end else if (paddr_in < `STATUS_ADDR) begin
            rd_data[15:0] = ctrl_r[ctrl_idx];
        end else begin
            case (paddr_in)
                `STATUS_ADDR: rd_data[`ST_W-1:0] = status_r;
                `MASK_ADDR:   rd_data[`ST_W-1:0] = mask_r;
                `SWREQ_ADDR:  rd_data = '0;
                `OUTCFG_ADDR: rd_data[2:0] = outcfg_r;
                default:      addr_ok = 1'b0;
            endcase
        end
    end

    // read data captured in the setup cycle, held through the access cycle
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            prdata_out <= '0;
        end else if (setup_ph && !pwrite_in) begin
            prdata_out <= rd_data;
        end
    end

    // trip control registers
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            for (int i = 0; i < `TRIP_CNT; i++) begin
                ctrl_r[i] <= `CTRL_RST;
            end
        end else if (wr_acc && paddr_in < `STATUS_ADDR) begin
            ctrl_r[ctrl_idx] <= pwdata_in[15:0] & `CTRL_WMASK;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            mask_r <= `MASK_RST;
        end else if (wr_acc && paddr_in == `MASK_ADDR) begin
            mask_r <= pwdata_in[`ST_W-1:0];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            outcfg_r <= `OUTCFG_RST;
        end else if (wr_acc && paddr_in == `OUTCFG_ADDR) begin
            outcfg_r <= pwdata_in[2:0];
        end
    end

    // active levels of the timer outputs
    assign mot_act = outcfg_r[`OC_MOT_LOW] ? ~motor_pwm_in : motor_pwm_in;
    assign pwm_act = outcfg_r[`OC_PWM_LOW] ? ~gen_pwm_in : gen_pwm_in;

    // motor index: ch0 A-D 0-3, ch3 B/D 4-5, ch4 A-D 6-9, ch6 B/D 10-11, ch7 A-D 12-15, ch9 A-D 16-19
    assign mot_short = (mot_act[4]  && mot_act[5])  ||
                       (mot_act[6]  && mot_act[8])  ||
                       (mot_act[7]  && mot_act[9])  ||
                       (mot_act[10] && mot_act[11]) ||
                       (mot_act[12] && mot_act[14]) ||
                       (mot_act[13] && mot_act[15]);

    // pwm index: channel c A at 2c, B at 2c+1; channel 3 unmonitored
    always_comb begin
        pwm_short = 1'b0;
        for (int c = 0; c < `PWM_PINS / 2; c++) begin
            if (c != 3 && pwm_act[2*c] && pwm_act[2*c+1]) begin
                pwm_short = 1'b1;
            end
        end
    end

    // event sources feeding the sticky flags
    always_comb begin
        set_vec                = '0;
        set_vec[`TRIP_CNT-1:0] = trip_req;
        set_vec[`ST_SW]        = sw_wr;
        set_vec[`ST_OSC]       = sync2_r[`TRIP_CNT];
        set_vec[`ST_CMP]       = |sync2_r[SYNC_W-1:`TRIP_CNT+1];
        set_vec[`ST_MSHORT]    = mot_short;
        set_vec[`ST_PSHORT]    = pwm_short;
    end

    // sticky flags; read clears only what was read, a new set wins
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            status_r <= '0;
        end else if (rd_status) begin
            status_r <= (status_r & ~prdata_out[`ST_W-1:0]) | set_vec;
        end else begin
            status_r <= status_r | set_vec;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status_r & mask_r);
        end
    end

    // motor short only stops motor pins, pwm short only pwm pins
    assign mot_dis = |status_r[`ST_CMP:0] || status_r[`ST_MSHORT];
    assign pwm_dis = |status_r[`ST_CMP:0] || status_r[`ST_PSHORT];

    // pin gating: release drive, optionally hand pin to the port
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            motor_pin_out      <= '0;
            motor_pin_oe_n_out <= '1;
            motor_gpio_sel_out <= '0;
        end else begin
            motor_pin_out      <= mot_dis ? '0 : motor_pwm_in;
            motor_pin_oe_n_out <= {`MOTOR_PINS{mot_dis}};
            motor_gpio_sel_out <= {`MOTOR_PINS{mot_dis && outcfg_r[`OC_GPIO]}};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            pwm_pin_out      <= '0;
            pwm_pin_oe_n_out <= '1;
            pwm_gpio_sel_out <= '0;
        end else begin
            pwm_pin_out      <= pwm_dis ? '0 : gen_pwm_in;
            pwm_pin_oe_n_out <= {`PWM_PINS{pwm_dis}};
            pwm_gpio_sel_out <= {`PWM_PINS{pwm_dis && outcfg_r[`OC_GPIO]}};
        end
    end

    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);

    a_sw_request: assert property (sw_wr |=> status_r[`ST_SW] ##1 (motor_pin_oe_n_out == '1 && pwm_pin_oe_n_out == '1))
        else $error("software request did not disable pins");
    a_osc_stop: assert property ($rose(sync2_r[`TRIP_CNT]) |=> status_r[`ST_OSC])
        else $error("oscillator stop not flagged");
    a_cmp_detect: assert property ($rose(|sync2_r[SYNC_W-1:`TRIP_CNT+1]) |=> status_r[`ST_CMP])
        else $error("comparator detection not flagged");
    a_motor_short: assert property (mot_short |=> status_r[`ST_MSHORT] ##1 motor_pin_oe_n_out == '1)
        else $error("motor short did not disable motor pins");
    a_pwm_short: assert property ((pwm_act[8] && pwm_act[9]) |=> status_r[`ST_PSHORT] ##1 pwm_pin_oe_n_out == '1)
        else $error("pwm short did not disable pwm pins");
    a_gpio_handoff: assert property ((mot_dis && outcfg_r[`OC_GPIO]) |=> motor_gpio_sel_out == '1)
        else $error("pin not handed to port");
    a_flag_holds: assert property ((status_r[`ST_MSHORT] && !rd_status) |=> status_r[`ST_MSHORT])
        else $error("flag dropped without a read");
    a_irq_mask: assert property ((|(status_r & mask_r)) |=> irq_out)
        else $error("unmasked flag did not raise interrupt");
    a_trip_flag: assert property (trip_req[0] |=> status_r[0] ##1 pwm_pin_oe_n_out == '1)
        else $error("trip request not latched");
    a_sync_delay: assert property ($fell(trip_in_n_in[0]) ##1 !trip_in_n_in[0] |=> !sync2_r[0])
        else $error("synchroniser depth wrong");

    c_sw_disable:  cover property (sw_wr ##2 motor_pin_oe_n_out == '1);
    c_motor_short: cover property (mot_short ##1 status_r[`ST_MSHORT]);
    c_read_clear:  cover property (rd_status ##1 status_r == '0);
endmodule

// file: sim/fault_side_model.sv
// output-disable trip controller: stand-in for trip pins, clock monitor, comparators and timers
// assumes the bench commands each source; every output changes just after a rising ref_clk_in
`timescale 1ns/1ps
module fault_side_model (
    // clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        srst_in,
    // commands from the bench
    input  wire logic [8:0]  trip_low_in,
    input  wire logic        osc_in,
    input  wire logic [3:0]  cmp_in,
    input  wire logic [19:0] mforce_in,
    input  wire logic [19:0] pforce_in,
    // sources seen by the controller
    output logic      [8:0]  trip_n_out = 9'h1FF,
    output logic             osc_out    = 1'b0,
    output logic      [3:0]  cmp_out    = 4'h0,
    output logic      [19:0] motor_out  = 20'h0_0000,
    output logic      [19:0] gen_out    = 20'h0_0000
);
    logic [1:0] phase_r = 2'h0;

    always @(posedge ref_clk_in) begin
        phase_r <= srst_in ? 2'h0 : phase_r + 2'h1;
        trip_n_out <= ~trip_low_in;
        osc_out <= osc_in;
        cmp_out <= cmp_in;
        // legs swap in one edge, so no overlap unless forced
        motor_out <= (phase_r[1] ? 20'h0_CB20 : 20'h0_34D0) | mforce_in;
        gen_out <= (phase_r[1] ? 20'hA_AAAA : 20'h5_5555) | pforce_in;
    end
endmodule

// file: sim/output_disable_trip_controller_tb.sv
// output-disable trip controller: self-checking bench
// assumes poe_map.svh on the include path and a zero-wait APB slave
`timescale 1ns/1ps
`include "poe_map.svh"
module output_disable_trip_controller_tb;
    import poe_pkg::*;
    logic                ref_clk_in = 1'b0;
    logic                srst_in    = 1'b1;
    logic [`ADDR_W-1:0]  paddr      = '0;
    logic                psel       = 1'b0;
    logic                penable    = 1'b0;
    logic                pwrite     = 1'b0;
    logic [31:0]         pwdata     = '0;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic [8:0]          trip_n;
    logic                osc;
    logic [3:0]          cmp;
    logic [19:0]         mpwm, gpwm, mpin, moe, mgpio, ppin, poe, pgpio;
    logic                irq;
    logic [8:0]          trip_low   = '0;
    logic                osc_cmd    = 1'b0;
    logic [3:0]          cmp_cmd    = '0;
    logic [19:0]         mforce     = '0;
    logic [19:0]         pforce     = '0;
    int                  num_errors = 0;
    int                  n_checks   = 0;
    int                  cycles     = 0;
    logic [31:0]         rdv;
    logic                errv;

    always #25 ref_clk_in = ~ref_clk_in;

    poe_ctrl dut_u (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .paddr_in(paddr), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .trip_in_n_in(trip_n), .osc_stop_in(osc),
        .cmp_det_in(cmp), .motor_pwm_in(mpwm), .gen_pwm_in(gpwm), .motor_pin_out(mpin),
        .motor_pin_oe_n_out(moe), .motor_gpio_sel_out(mgpio), .pwm_pin_out(ppin),
        .pwm_pin_oe_n_out(poe), .pwm_gpio_sel_out(pgpio), .irq_out(irq));

    fault_side_model far_u (.ref_clk_in(ref_clk_in), .srst_in(srst_in), .trip_low_in(trip_low),
        .osc_in(osc_cmd), .cmp_in(cmp_cmd), .mforce_in(mforce), .pforce_in(pforce),
        .trip_n_out(trip_n), .osc_out(osc), .cmp_out(cmp), .motor_out(mpwm), .gen_out(gpwm));

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    task automatic apb(input logic wr, input logic [`ADDR_W-1:0] a, input logic [31:0] wd);
        @(posedge ref_clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk_in);
        penable <= 1'b1;
        do @(posedge ref_clk_in); while (pready !== 1'b1);
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [`ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdv, exp);
    endtask

    task automatic t_regs();
        rd_chk(`TRIP_CTRL_BASE, 32'h0000_0000);
        rd_chk(`MASK_ADDR, 32'h0000_0000);
        rd_chk(`OUTCFG_ADDR, 32'h0000_0000);
        rd_chk(`STATUS_ADDR, 32'h0000_0000);
        apb(1'b1, `TRIP_CTRL_BASE + 12'h020, 32'hFFFF_FFF5);
        rd_chk(`TRIP_CTRL_BASE + 12'h020, 32'h0000_0F05);
        apb(1'b0, 12'h0FC, 32'h0000_0000);
        chk({31'h0, errv}, 32'h0000_0001);
        #1 chk({12'h0, moe | poe}, 32'h0000_0000);
        chk({12'h0, (ppin ^ (ppin >> 1)) & 20'h5_5555}, 32'h0005_5555);
        chk({31'h0, mpin[15:4] == 12'h34D || mpin[15:4] == 12'hCB2}, 32'h0000_0001);
        $display("test regs done");
    endtask

    task automatic t_sw();
        apb(1'b1, `OUTCFG_ADDR, 32'h0000_0001);
        apb(1'b1, `SWREQ_ADDR, 32'h0000_0000);
        cyc(4);
        #1 chk({12'h0, moe & poe & mgpio & pgpio}, 32'h000F_FFFF);
        chk({12'h0, mpin | ppin}, 32'h0000_0000);
        rd_chk(`STATUS_ADDR, 32'h0000_0200);
        cyc(4);
        #1 chk({12'h0, moe | pgpio}, 32'h0000_0000);
        apb(1'b1, `OUTCFG_ADDR, 32'h0000_0000);
        $display("test software request done");
    endtask

    task automatic t_edge();
        apb(1'b1, `MASK_ADDR, 32'h0000_0001);
        trip_low[0] <= 1'b1;
        cyc(3);
        trip_low[0] <= 1'b0;
        cyc(6);
        #1 chk({31'h0, irq}, 32'h0000_0001);
        chk({12'h0, moe}, 32'h000F_FFFF);
        rd_chk(`STATUS_ADDR, 32'h0000_0001);
        cyc(3);
        #1 chk({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, `MASK_ADDR, 32'h0000_0000);
        $display("test edge trip done");
    endtask

    task automatic t_level();
        int mode_t[7] = '{1, 2, 3, 4, 5, 6, 4};
        int div_t[7] = '{8, 16, 128, 1, 2, 4, 1};
        int cnt_t[7] = '{4, 4, 4, 4, 8, 16, 16};
        logic [3:0] sel;
        for (int k = 0; k < 7; k++) begin
            sel = (cnt_t[k] == 4) ? `CNT_SEL_4 : (cnt_t[k] == 8) ? `CNT_SEL_8 : `CNT_SEL_16;
            apb(1'b1, `TRIP_CTRL_BASE + 12'h004, {20'h0, sel, 4'h0, 4'(mode_t[k])});
            cyc(div_t[k] + 2);
            trip_low[1] <= 1'b1;
            cyc((cnt_t[k] - 1) * div_t[k]);
            trip_low[1] <= 1'b0;
            cyc(6);
            rd_chk(`STATUS_ADDR, 32'h0000_0000);
            trip_low[1] <= 1'b1;
            cyc((cnt_t[k] + 1) * div_t[k] + 4);
            trip_low[1] <= 1'b0;
            cyc(4);
            rd_chk(`STATUS_ADDR, 32'h0000_0002);
            rd_chk(`STATUS_ADDR, 32'h0000_0000);
        end
        $display("test level trip done");
    endtask

    task automatic t_osc_cmp();
        osc_cmd <= 1'b1;
        cyc(3);
        osc_cmd <= 1'b0;
        cyc(5);
        rd_chk(`STATUS_ADDR, 32'h0000_0400);
        cmp_cmd[2] <= 1'b1;
        cyc(3);
        cmp_cmd[2] <= 1'b0;
        cyc(5);
        rd_chk(`STATUS_ADDR, 32'h0000_0800);
        $display("test oscillator and comparator done");
    endtask

    task automatic t_short();
        apb(1'b1, `MASK_ADDR, 32'h0000_3000);
        mforce <= 20'h0_0030;
        cyc(1);
        mforce <= 20'h0_0000;
        cyc(4);
        #1 chk({12'h0, moe ^ poe}, 32'h000F_FFFF);
        chk({31'h0, irq}, 32'h0000_0001);
        rd_chk(`STATUS_ADDR, 32'h0000_1000);
        pforce <= 20'h0_00C0;
        cyc(2);
        pforce <= 20'h0_0300;
        cyc(1);
        pforce <= 20'h0_0000;
        cyc(4);
        #1 chk({12'h0, poe & ~moe}, 32'h000F_FFFF);
        rd_chk(`STATUS_ADDR, 32'h0000_2000);
        apb(1'b1, `MASK_ADDR, 32'h0000_0000);
        $display("test short circuit done");
    endtask

    initial begin
        cyc(16);
        srst_in <= 1'b0;
        cyc(4);
        t_regs();
        t_sw();
        t_edge();
        t_level();
        t_osc_cmp();
        t_short();
        final_report();
    end
endmodule
